// [hw/mst_selftest_ctrl.sv]
`timescale 1ns/1ns
// Behaviour
// RULE1 - Six supply tests, each gated by monitor enable
// RULE2 - Passing test sets active-low fault flag
// RULE3 - Three oscillation tests, gated, set oscillation flags
// RULE4 - Three ground-open tests, gated, set disconnect flags
// RULE5 - Supply register bits 6:3 read zero
// RULE6 - Clock register bits 15:4 plain spare storage
// RULE7 - Too-fast test forces frequency fault when enabled
// RULE8 - Too-slow test forces same frequency fault
// RULE9 - Software never sets both frequency tests together
// RULE10 - Backup oscillator watchdog test, gated by enable
// RULE11 - Main clock watchdog test, gated by enable
// RULE12 - Two-bit CRC pattern select, zero disables
// RULE13 - Readback inversion only on output-direction pins
// RULE14 - Digital register bits 15:10, 7:3 read zero
// RULE15 - All self-test registers reset to zero
// RULE16 - Unmasked fault flags drive summary fault
// RULE17 - Software clears test and sees recovery first
module mst_selftest_ctrl #(
    parameter int WAIT_CYCLES = mst_pkg::TEST_WAIT_CYCLES
) (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire mst_pkg::mst_bus_req_type  bus_req,
    output logic [15:0]                    bus_rdata,
    input  wire logic [15:0]               supply_monitor_on,
    input  wire logic                      clock_frequency_monitor_on,
    input  wire logic                      backup_osc_watchdog_on,
    input  wire logic                      main_clock_watchdog_on,
    input  wire logic [15:0]               supply_fault_n,
    input  wire logic                      clock_frequency_fault_flag_n,
    input  wire logic                      backup_osc_watchdog_fault_n,
    input  wire logic                      main_clock_watchdog_fault_n,
    input  wire logic                      memory_crc_fault_flag_n,
    input  wire mst_pkg::mst_pin_pair_type pin_value,
    input  wire mst_pkg::mst_pin_pair_type pin_direction,
    output logic [15:0]                    supply_test_force,
    output logic                           clock_too_fast_force,
    output logic                           clock_too_slow_force,
    output logic                           backup_osc_watchdog_force,
    output logic                           main_clock_watchdog_force,
    output logic [1:0]                     memory_crc_test_pattern,
    output mst_pkg::mst_pin_pair_type      pin_readback,
    output logic                           power_summary_fault_n,
    output logic                           irq
);

    // Any forced monitor that already shows its fault
    function automatic logic flag_hit(
        input logic [15:0] force_vec,
        input logic [15:0] fault_n_vec
    );
        flag_hit = |(force_vec & ~fault_n_vec);
    endfunction

    logic [15:0]               supply_cfg_reg;
    logic [15:0]               clock_cfg_reg;
    logic [15:0]               digital_cfg_reg;
    logic [15:0]               flag_gate_reg;
    logic [mst_pkg::EV_W-1:0]  event_stat_reg;
    logic [mst_pkg::EV_W-1:0]  event_mask_reg;
    logic [mst_pkg::EV_W-1:0]  event_set;
    logic [15:0]               rdata_next;
    logic [15:0]               clock_force_vec;
    logic [15:0]               clock_fault_vec;
    logic                      freq_conflict;
    logic                      any_active;
    logic                      supply_hit;
    logic                      clock_hit;
    logic                      crc_hit;
    logic                      supply_hit_reg;
    logic                      clock_hit_reg;
    logic                      crc_hit_reg;
    logic                      wr_stat;
    logic                      wr_conflict;
    mst_pkg::mst_watch_type    watch_reg;
    mst_pkg::mst_watch_type    watch_next;
    logic [15:0]               wait_cnt_reg;
    logic [15:0]               wait_cnt_next;

    localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYCLES - 1);

    // Register writes

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            supply_cfg_reg <= mst_pkg::REG_RESET; // [RULE15]
        end else if (bus_req.wr && bus_req.addr == mst_pkg::SUPPLY_CFG_OFS) begin
            // Unused bits never store, so they read back zero
            supply_cfg_reg <= bus_req.wdata & mst_pkg::SUPPLY_WR_MASK; // [RULE5]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clock_cfg_reg <= mst_pkg::REG_RESET; // [RULE15]
        end else if (bus_req.wr && bus_req.addr == mst_pkg::CLOCK_CFG_OFS) begin
            // Upper spare bits only store and read back
            clock_cfg_reg <= bus_req.wdata & mst_pkg::CLOCK_WR_MASK; // [RULE6]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            digital_cfg_reg <= mst_pkg::REG_RESET; // [RULE15]
        end else if (bus_req.wr && bus_req.addr == mst_pkg::DIGITAL_CFG_OFS) begin
            digital_cfg_reg <= bus_req.wdata & mst_pkg::DIGITAL_WR_MASK; // [RULE14]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flag_gate_reg <= mst_pkg::REG_RESET;
        end else if (bus_req.wr && bus_req.addr == mst_pkg::FLAG_GATE_OFS) begin
            flag_gate_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            event_mask_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == mst_pkg::EVENT_MASK_OFS) begin
            event_mask_reg <= bus_req.wdata[mst_pkg::EV_W-1:0];
        end
    end

    // Monitor forcing

    // Both frequency tests at once would cancel each other in the monitor,
    // so neither is forced until software resolves it
    assign freq_conflict = clock_cfg_reg[mst_pkg::CLK_FAST_BIT]
                         & clock_cfg_reg[mst_pkg::CLK_SLOW_BIT]; // [RULE9]

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            supply_test_force <= '0;
        end else begin
            // Over/undervoltage, oscillation and ground-open share one layout
            supply_test_force <= supply_cfg_reg & supply_monitor_on; // [RULE1] [RULE3] [RULE4]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clock_too_fast_force      <= 1'b0;
            clock_too_slow_force      <= 1'b0;
            backup_osc_watchdog_force <= 1'b0;
            main_clock_watchdog_force <= 1'b0;
        end else begin
            clock_too_fast_force <= clock_cfg_reg[mst_pkg::CLK_FAST_BIT]
                                  & clock_frequency_monitor_on
                                  & ~freq_conflict; // [RULE7]
            clock_too_slow_force <= clock_cfg_reg[mst_pkg::CLK_SLOW_BIT]
                                  & clock_frequency_monitor_on
                                  & ~freq_conflict; // [RULE8]
            backup_osc_watchdog_force <= clock_cfg_reg[mst_pkg::OSC_WD_BIT]
                                       & backup_osc_watchdog_on; // [RULE10]
            main_clock_watchdog_force <= clock_cfg_reg[mst_pkg::MAIN_WD_BIT]
                                       & main_clock_watchdog_on; // [RULE11]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            memory_crc_test_pattern <= mst_pkg::CRC_PAT_OFF;
        end else begin
            memory_crc_test_pattern <=
                digital_cfg_reg[mst_pkg::CRC_PAT_MSB:mst_pkg::CRC_PAT_LSB]; // [RULE12]
        end
    end

    // Pin readback path

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_readback <= '0;
        end else begin
            // Only output pins invert, so input readings stay trustworthy
            pin_readback.grp_a <= pin_value.grp_a
                ^ (pin_direction.grp_a & {2{digital_cfg_reg[mst_pkg::GRP_A_BIT]}}); // [RULE13]
            pin_readback.grp_b <= pin_value.grp_b
                ^ (pin_direction.grp_b & {2{digital_cfg_reg[mst_pkg::GRP_B_BIT]}}); // [RULE13]
            pin_readback.grp_main <= pin_value.grp_main
                ^ (pin_direction.grp_main & {2{digital_cfg_reg[mst_pkg::GRP_MAIN_BIT]}}); // [RULE13]
        end
    end

    // Summary fault flag

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            power_summary_fault_n <= 1'b1;
        end else begin
            power_summary_fault_n <= ~|(~supply_fault_n & ~flag_gate_reg); // [RULE16]
        end
    end

    // Answer watch

    assign clock_force_vec = {12'h000,
                              clock_too_fast_force | clock_too_slow_force,
                              1'b0,
                              backup_osc_watchdog_force,
                              main_clock_watchdog_force};
    assign clock_fault_vec = {12'hfff,
                              clock_frequency_fault_flag_n,
                              1'b1,
                              backup_osc_watchdog_fault_n,
                              main_clock_watchdog_fault_n};

    assign supply_hit = flag_hit(supply_test_force, supply_fault_n); // [RULE2]
    assign clock_hit  = flag_hit(clock_force_vec, clock_fault_vec); // [RULE2]
    assign crc_hit    = (memory_crc_test_pattern != mst_pkg::CRC_PAT_OFF)
                      & ~memory_crc_fault_flag_n; // [RULE12]
    assign any_active = (|supply_test_force) | (|clock_force_vec)
                      | (memory_crc_test_pattern != mst_pkg::CRC_PAT_OFF);

    always_comb begin
        watch_next    = watch_reg;
        wait_cnt_next = wait_cnt_reg;
        unique case (watch_reg)
            mst_pkg::WATCH_IDLE: begin
                wait_cnt_next = '0;
                if (any_active) begin
                    watch_next = mst_pkg::WATCH_WAIT;
                end
            end
            mst_pkg::WATCH_WAIT: begin
                if (!any_active) begin
                    watch_next = mst_pkg::WATCH_IDLE;
                end else if (supply_hit || clock_hit || crc_hit) begin
                    watch_next = mst_pkg::WATCH_PASS; // [RULE2]
                end else if (wait_cnt_reg == WAIT_LAST) begin
                    watch_next = mst_pkg::WATCH_FAIL;
                end else begin
                    wait_cnt_next = wait_cnt_reg + 16'h0001;
                end
            end
            mst_pkg::WATCH_PASS, mst_pkg::WATCH_FAIL: begin
                // Idle only once the test is cleared
                if (!any_active) begin
                    watch_next = mst_pkg::WATCH_IDLE; // [RULE17]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            watch_reg    <= mst_pkg::WATCH_IDLE;
            wait_cnt_reg <= '0;
        end else begin
            watch_reg    <= watch_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            supply_hit_reg <= 1'b0;
            clock_hit_reg  <= 1'b0;
            crc_hit_reg    <= 1'b0;
        end else begin
            supply_hit_reg <= supply_hit;
            clock_hit_reg  <= clock_hit;
            crc_hit_reg    <= crc_hit;
        end
    end

    // Events and interrupt

    assign wr_conflict = bus_req.wr && bus_req.addr == mst_pkg::CLOCK_CFG_OFS
                       && bus_req.wdata[mst_pkg::CLK_FAST_BIT]
                       && bus_req.wdata[mst_pkg::CLK_SLOW_BIT]; // [RULE9]

    always_comb begin
        event_set = '0;
        event_set[mst_pkg::EV_SUPPLY_PASS] = supply_hit & ~supply_hit_reg;
        event_set[mst_pkg::EV_CLOCK_PASS]  = clock_hit & ~clock_hit_reg;
        event_set[mst_pkg::EV_CRC_PASS]    = crc_hit & ~crc_hit_reg;
        event_set[mst_pkg::EV_TIMEOUT]     = (watch_reg == mst_pkg::WATCH_WAIT)
                                           & (watch_next == mst_pkg::WATCH_FAIL);
        event_set[mst_pkg::EV_CONFLICT]    = wr_conflict;
    end

    assign wr_stat = bus_req.wr && bus_req.addr == mst_pkg::EVENT_STAT_OFS;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            event_stat_reg <= '0;
        end else if (wr_stat) begin
            // A new event in the clearing cycle stays set
            event_stat_reg <= (event_stat_reg & ~bus_req.wdata[mst_pkg::EV_W-1:0])
                            | event_set;
        end else begin
            event_stat_reg <= event_stat_reg | event_set;
        end
    end

    assign irq = |(event_stat_reg & event_mask_reg);

    // Register reads

    always_comb begin
        rdata_next = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                mst_pkg::SUPPLY_CFG_OFS:  rdata_next = supply_cfg_reg;
                mst_pkg::CLOCK_CFG_OFS:   rdata_next = clock_cfg_reg;
                mst_pkg::DIGITAL_CFG_OFS: rdata_next = digital_cfg_reg;
                mst_pkg::FLAG_GATE_OFS:   rdata_next = flag_gate_reg;
                mst_pkg::EVENT_STAT_OFS:  rdata_next = {11'h000, event_stat_reg};
                mst_pkg::EVENT_MASK_OFS:  rdata_next = {11'h000, event_mask_reg};
                default:                  rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= rdata_next;
        end
    end

endmodule // mst_selftest_ctrl

// [hw/mst_pkg.sv]
package mst_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets, one 16-bit register per address
    localparam logic [7:0] SUPPLY_CFG_OFS  = 8'h44;
    localparam logic [7:0] CLOCK_CFG_OFS   = 8'h45;
    localparam logic [7:0] DIGITAL_CFG_OFS = 8'h46;
    localparam logic [7:0] FLAG_GATE_OFS   = 8'h47;
    localparam logic [7:0] EVENT_STAT_OFS  = 8'h50;
    localparam logic [7:0] EVENT_MASK_OFS  = 8'h51;

    localparam logic [15:0] REG_RESET       = 16'h0000;
    localparam logic [15:0] SUPPLY_WR_MASK  = 16'hff87;
    localparam logic [15:0] CLOCK_WR_MASK   = 16'hffff;
    localparam logic [15:0] DIGITAL_WR_MASK = 16'h0307;

    // Clock self-test field positions
    localparam int CLK_FAST_BIT = 3;
    localparam int CLK_SLOW_BIT = 2;
    localparam int OSC_WD_BIT   = 1;
    localparam int MAIN_WD_BIT  = 0;

    // Digital self-test field positions
    localparam int CRC_PAT_LSB  = 8;
    localparam int CRC_PAT_MSB  = 9;
    localparam int GRP_A_BIT    = 2;
    localparam int GRP_B_BIT    = 1;
    localparam int GRP_MAIN_BIT = 0;
    localparam logic [1:0] CRC_PAT_OFF = 2'h0;

    // Event status bit positions
    localparam int EV_SUPPLY_PASS = 0;
    localparam int EV_CLOCK_PASS  = 1;
    localparam int EV_CRC_PASS    = 2;
    localparam int EV_TIMEOUT     = 3;
    localparam int EV_CONFLICT    = 4;
    localparam int EV_W           = 5;

    // Wait for a forced monitor to answer, in clock cycles
    localparam int TEST_WAIT_CYCLES = 1000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mst_bus_req_type;

    typedef struct packed {
        logic [1:0] grp_a;
        logic [1:0] grp_b;
        logic [1:0] grp_main;
    } mst_pin_pair_type;

    typedef enum logic [1:0] {
        WATCH_IDLE = 2'b00,
        WATCH_WAIT = 2'b01,
        WATCH_PASS = 2'b11,
        WATCH_FAIL = 2'b10
    } mst_watch_type;

endpackage

// [dv/mst_selftest_ctrl_assertions.sv]
`timescale 1ns/1ns
module mst_selftest_ctrl_checker (
    input wire logic                      core_clk,
    input wire logic                      resetn,
    input wire mst_pkg::mst_bus_req_type  bus_req,
    input wire logic [15:0]               supply_monitor_on,
    input wire logic                      clock_frequency_monitor_on,
    input wire logic                      backup_osc_watchdog_on,
    input wire logic                      main_clock_watchdog_on,
    input wire logic [15:0]               supply_fault_n,
    input wire mst_pkg::mst_pin_pair_type pin_value,
    input wire mst_pkg::mst_pin_pair_type pin_direction,
    input wire logic [15:0]               supply_test_force,
    input wire logic                      clock_too_fast_force,
    input wire logic                      clock_too_slow_force,
    input wire logic                      backup_osc_watchdog_force,
    input wire logic                      main_clock_watchdog_force,
    input wire logic [1:0]                memory_crc_test_pattern,
    input wire mst_pkg::mst_pin_pair_type pin_readback,
    input wire logic                      power_summary_fault_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Guarding on the previous reset level keeps the first edge after release quiet
    supply_gate_a: assert property (
        $past(resetn) |-> (supply_test_force & ~$past(supply_monitor_on)) == 16'h0000)
        else $error("supply force without its monitor enable");
    supply_rsvd_a: assert property (supply_test_force[6:3] == 4'h0)
        else $error("reserved supply bits forced");
    fast_gate_a: assert property (
        $past(resetn) && clock_too_fast_force |-> $past(clock_frequency_monitor_on))
        else $error("too-fast force without frequency monitor");
    slow_gate_a: assert property (
        $past(resetn) && clock_too_slow_force |-> $past(clock_frequency_monitor_on))
        else $error("too-slow force without frequency monitor");
    freq_excl_a: assert property (!(clock_too_fast_force && clock_too_slow_force))
        else $error("both frequency forces at once");
    osc_wd_gate_a: assert property (
        $past(resetn) && backup_osc_watchdog_force |-> $past(backup_osc_watchdog_on))
        else $error("backup watchdog force without enable");
    main_wd_gate_a: assert property (
        $past(resetn) && main_clock_watchdog_force |-> $past(main_clock_watchdog_on))
        else $error("main watchdog force without enable");
    crc_hold_a: assert property (
        $past(resetn, 2) && $past(resetn) && !($past(bus_req.wr, 2)
            && $past(bus_req.addr, 2) == mst_pkg::DIGITAL_CFG_OFS)
        |-> $stable(memory_crc_test_pattern))
        else $error("crc pattern moved without a write");
    readback_pass_a: assert property (
        $past(resetn) |-> ((pin_readback ^ $past(pin_value)) & ~$past(pin_direction)) == 6'h00)
        else $error("input-direction pin readback altered");
    summary_clear_a: assert property (
        $past(resetn) && $past(&supply_fault_n) |-> power_summary_fault_n)
        else $error("summary fault without any fault flag");
endmodule // mst_selftest_ctrl_checker

bind mst_selftest_ctrl mst_selftest_ctrl_checker u_mst_selftest_ctrl_checker (.*);

// [dv/tb_mst_selftest_ctrl.sv]
`timescale 1ns/1ns
module tb_mst_selftest_ctrl;
    localparam int          WAIT_N = 8;
    localparam logic [15:0] RMASK [4] = '{16'hff87, 16'hffff, 16'h0307, 16'hffff};
    // Clock cfg nibble, then expected fast, slow, backup, main forces
    localparam logic [7:0]  CCASE [5] = '{8'h88, 8'h44, 8'h22, 8'h11, 8'hc0};
    logic                      core_clk;
    logic                      resetn;
    mst_pkg::mst_bus_req_type  bus_req;
    logic [15:0]               bus_rdata;
    logic [15:0]               supply_monitor_on;
    logic                      clock_frequency_monitor_on;
    logic                      backup_osc_watchdog_on;
    logic                      main_clock_watchdog_on;
    logic [15:0]               supply_fault_n;
    logic                      clock_frequency_fault_flag_n;
    logic                      backup_osc_watchdog_fault_n;
    logic                      main_clock_watchdog_fault_n;
    logic                      memory_crc_fault_flag_n;
    mst_pkg::mst_pin_pair_type pin_value;
    mst_pkg::mst_pin_pair_type pin_direction;
    logic [15:0]               supply_test_force;
    logic                      clock_too_fast_force;
    logic                      clock_too_slow_force;
    logic                      backup_osc_watchdog_force;
    logic                      main_clock_watchdog_force;
    logic [1:0]                memory_crc_test_pattern;
    mst_pkg::mst_pin_pair_type pin_readback;
    logic                      power_summary_fault_n;
    logic                      irq;
    logic [3:0]                clk_force;
    int                        n_errors;
    int                        checks_done;
    int                        cycles;

    assign clk_force = {clock_too_fast_force, clock_too_slow_force,
                        backup_osc_watchdog_force, main_clock_watchdog_force};

    mst_selftest_ctrl #(.WAIT_CYCLES(WAIT_N)) u_mst_selftest_ctrl (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so it is sampled there
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        chk("read data", exp, bus_rdata & m);
    endtask

    task automatic end_sim;
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        resetn = 1'b0;
        bus_req = '0;
        supply_monitor_on = 16'h0000;
        clock_frequency_monitor_on = 1'b0;
        backup_osc_watchdog_on = 1'b0;
        main_clock_watchdog_on = 1'b0;
        supply_fault_n = 16'hffff;
        clock_frequency_fault_flag_n = 1'b1;
        backup_osc_watchdog_fault_n = 1'b1;
        main_clock_watchdog_fault_n = 1'b1;
        memory_crc_fault_flag_n = 1'b1;
        pin_value = '0;
        pin_direction = '0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(mst_pkg::SUPPLY_CFG_OFS + 8'(i), 16'h0000, 16'hffff);
        rd(mst_pkg::EVENT_STAT_OFS, 16'h0000, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            wr(mst_pkg::SUPPLY_CFG_OFS + 8'(i), 16'hffff);
            rd(mst_pkg::SUPPLY_CFG_OFS + 8'(i), RMASK[i], 16'hffff);
        end
        wr(8'h4a, 16'hffff);
        rd(8'h4a, 16'h0000, 16'hffff);
        @(posedge core_clk);
        supply_fault_n <= 16'h7fff;
        tick(2);
        chk("summary fault", 16'h0001, {15'h0000, power_summary_fault_n});
        wr(mst_pkg::FLAG_GATE_OFS, 16'h7fff);
        tick(1);
        chk("summary fault", 16'h0000, {15'h0000, power_summary_fault_n});
        chk("supply force", 16'h0000, supply_test_force);
        @(posedge core_clk);
        supply_monitor_on <= 16'h80ff;
        supply_fault_n <= 16'hffff;
        tick(1);
        chk("supply force", 16'h8087, supply_test_force);
        for (int i = 0; i < 3; i++) wr(mst_pkg::SUPPLY_CFG_OFS + 8'(i), 16'h0000);
        tick(2);
        wr(mst_pkg::EVENT_STAT_OFS, 16'h001f);
        wr(mst_pkg::SUPPLY_CFG_OFS, 16'h8000);
        tick(2);
        @(posedge core_clk);
        supply_fault_n <= 16'h7fff;
        tick(2);
        rd(mst_pkg::EVENT_STAT_OFS, 16'h0001, 16'hffff);
        wr(mst_pkg::EVENT_MASK_OFS, 16'h0001);
        tick(0);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(mst_pkg::EVENT_STAT_OFS, 16'h0001);
        tick(0);
        chk("irq", 16'h0000, {15'h0000, irq});
        @(posedge core_clk);
        supply_fault_n <= 16'hffff;
        wr(mst_pkg::SUPPLY_CFG_OFS, 16'h0000);
        main_clock_watchdog_on <= 1'b1;
        tick(2);
        wr(mst_pkg::EVENT_STAT_OFS, 16'h001f);
        wr(mst_pkg::CLOCK_CFG_OFS, 16'h0001);
        tick(WAIT_N + 4);
        rd(mst_pkg::EVENT_STAT_OFS, 16'h0008, 16'hffff);
        @(posedge core_clk);
        main_clock_watchdog_fault_n <= 1'b0;
        tick(2);
        rd(mst_pkg::EVENT_STAT_OFS, 16'h0002, 16'h0002);
        @(posedge core_clk);
        main_clock_watchdog_fault_n <= 1'b1;
        clock_frequency_monitor_on <= 1'b1;
        backup_osc_watchdog_on <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(mst_pkg::CLOCK_CFG_OFS, {12'h000, CCASE[i][7:4]});
            tick(1);
            chk("clock forces", {12'h000, CCASE[i][3:0]}, {12'h000, clk_force});
        end
        rd(mst_pkg::EVENT_STAT_OFS, 16'h0010, 16'h0010);
        @(posedge core_clk);
        clock_frequency_monitor_on <= 1'b0;
        backup_osc_watchdog_on <= 1'b0;
        main_clock_watchdog_on <= 1'b0;
        wr(mst_pkg::CLOCK_CFG_OFS, 16'h0007);
        tick(1);
        chk("clock forces", 16'h0000, {12'h000, clk_force});
        wr(mst_pkg::CLOCK_CFG_OFS, 16'h0000);
        tick(2);
        wr(mst_pkg::EVENT_STAT_OFS, 16'h001f);
        wr(mst_pkg::DIGITAL_CFG_OFS, 16'h0100);
        tick(1);
        @(posedge core_clk);
        memory_crc_fault_flag_n <= 1'b0;
        tick(2);
        rd(mst_pkg::EVENT_STAT_OFS, 16'h0004, 16'h0004);
        @(posedge core_clk);
        memory_crc_fault_flag_n <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            wr(mst_pkg::DIGITAL_CFG_OFS, {6'h00, 2'(p), 8'h00});
            tick(1);
            chk("crc pattern", 16'(p), {14'h0000, memory_crc_test_pattern});
        end
        @(posedge core_clk);
        pin_value <= 6'b10_01_11;
        pin_direction <= 6'b11_01_00;
        wr(mst_pkg::DIGITAL_CFG_OFS, 16'h0007);
        tick(1);
        chk("pin readback", 16'h0013, {10'h000, pin_readback});
        wr(mst_pkg::DIGITAL_CFG_OFS, 16'h0004);
        tick(1);
        chk("pin readback", 16'h0017, {10'h000, pin_readback});
        @(posedge core_clk);
        resetn <= 1'b0;
        tick(1);
        chk("pin readback", 16'h0000, {10'h000, pin_readback});
        @(posedge core_clk);
        resetn <= 1'b1;
        rd(mst_pkg::DIGITAL_CFG_OFS, 16'h0000, 16'hffff);
        rd(mst_pkg::FLAG_GATE_OFS, 16'h0000, 16'hffff);
        end_sim();
    end
endmodule // tb_mst_selftest_ctrl
